// *** bdp_defs.svh ***
`ifndef BDP_DEFS_SVH
`define BDP_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BDP_OFF_CTRL      8'h00
`define BDP_OFF_ASI_ADDR  8'h04
`define BDP_OFF_ASI_CMD   8'h08
`define BDP_OFF_ASI_RDATA 8'h0c
`define BDP_OFF_STATUS    8'h10
`define BDP_OFF_BRK       8'h14
`define BDP_OFF_PIPE      8'h18

// ----------------------------------------
// Alternate space code, test addresses and boot vector
// ----------------------------------------
`define BDP_ASI_SELFTEST  8'h39
`define BDP_VA_SHORT      32'h0000_0000
`define BDP_VA_LONG       32'h0000_0100
`define BDP_BOOT_VECTOR   32'hff00_0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BDP_CMD_STORE_BIT 0
`define BDP_CMD_LOAD_BIT  1
`define BDP_CMD_ASI_LSB   8
`define BDP_CTRL_PAR_BIT  0
`define BDP_CTRL_TEST_BIT 1
`define BDP_CTRL_JREQ_BIT 2
`define BDP_BRK_CODE_BIT  0
`define BDP_BRK_DATA_BIT  1
`define BDP_BRK_CYC_BIT   2
`define BDP_BRK_HIT_LSB   4

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define BDP_CTRL_RESET    32'h0000_0001
`define BDP_SHORT_CYCLES  16'd256
`define BDP_LONG_CYCLES   16'd1024
`define BDP_RST_CYCLES    4'd8
`define BDP_STROBE_CYCLES 4'd2
`define BDP_SEED          32'hffff_ffff

`endif

// *** bdp_pkg.sv ***
package bdp_pkg;

  typedef enum logic [2:0] {
    BDP_IDLE,
    BDP_RUN,
    BDP_RESET,
    BDP_BOOT
  } bdp_state_t;

  typedef struct packed {
    logic        done;
    logic        pass;
    logic        aborted;
    logic        long_run;
  } bdp_status_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic        hwrite;
    logic        hsel;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
  } bdp_ahb_addr_t;

endpackage

// *** bdp_misr.sv ***
`include "bdp_defs.svh"

module bdp_misr (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clear,
  input  wire logic        step,
  input  wire logic [31:0] data,
  output logic [31:0]      sig
);

  logic [31:0] sig_q;
  logic [31:0] sig_d;

  // Signature compactor, CRC-32 polynomial shifted per step
  assign sig_d = clear ? `BDP_SEED :
                 step  ? ({sig_q[30:0], 1'b0}
                          ^ (sig_q[31] ? 32'h04c1_1db7 : 32'h0000_0000)
                          ^ data) :
                 sig_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sig_q <= `BDP_SEED;
    end else begin
      sig_q <= sig_d;
    end
  end

  assign sig = sig_q;

endmodule // bdp_misr

// *** bdp_top.sv ***
// Contract
// [RULE1] Store to space 0x39 starts self test
// [RULE2] Address 0x0 short, 0x100 long test
// [RULE3] Sequencer runs test without software
// [RULE4] External reset aborts running test
// [RULE5] Completion raises internal reset pulse
// [RULE6] Loads return status 0x100, signature 0x0
// [RULE7] Internal reset clears parity enable
// [RULE8] Internal reset hidden from cache controller
// [RULE9] Only short test signature is meaningful
// [RULE10] Programmable strobe on breakpoint match
// [RULE11] Code, data or cycle breakpoint trigger
// [RULE12] Ten-bit pipeline monitor output
// [RULE13] Test input floats outputs except strobe; here it floats only the pipeline monitor bus, via pipe_oe_n
// [RULE14] No state preserved after test input; here test_pin clears no state and sets the sticky test_seen_q
// [RULE15] Scan port may request self test
// [RULE16] Scan logic reset done externally
// [RULE17] After reset, boot and fetch 0xff000000
// [RULE18] Aborted test never reports a pass
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`include "bdp_defs.svh"

module bdp_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_reset_n,
  input  wire logic        test_pin,
  input  wire logic        scan_bist_req,
  input  wire logic        code_bp_hit,
  input  wire logic        data_bp_hit,
  input  wire logic        cycle_bp_hit,
  input  wire logic [9:0]  pipe_state,
  output logic             breakpoint_strobe_out,
  output logic [9:0]       pipeline_monitor_bus,
  output logic             pipe_oe_n,
  output logic             internal_reset,
  output logic             boot_fetch,
  output logic [31:0]      boot_addr,
  output logic             parity_enable
);

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  bdp_pkg::bdp_ahb_addr_t ap_q;
  bdp_pkg::bdp_ahb_addr_t ap_d;
  logic                   dp_wr;
  logic                   dp_rd;

  assign ap_d.haddr  = haddr;
  assign ap_d.hwrite = hwrite;
  assign ap_d.hsel   = hsel & htrans[1] & hready;
  assign ap_d.htrans = htrans;
  assign ap_d.hsize  = hsize;
  assign dp_wr       = ap_q.hsel & ap_q.hwrite;
  assign dp_rd       = ap_q.hsel & ~ap_q.hwrite;

  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[7:0] == off) && (a[31:8] == 24'h00_0000);
  endfunction

  wire sel_ctrl  = hit(ap_q.haddr, `BDP_OFF_CTRL);
  wire sel_addr  = hit(ap_q.haddr, `BDP_OFF_ASI_ADDR);
  wire sel_cmd   = hit(ap_q.haddr, `BDP_OFF_ASI_CMD);
  wire sel_rdat  = hit(ap_q.haddr, `BDP_OFF_ASI_RDATA);
  wire sel_stat  = hit(ap_q.haddr, `BDP_OFF_STATUS);
  wire sel_brk   = hit(ap_q.haddr, `BDP_OFF_BRK);
  wire sel_pipe  = hit(ap_q.haddr, `BDP_OFF_PIPE);

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [31:0]            ctrl_q;
  logic [31:0]            va_q;
  logic [2:0]             brk_en_q;
  logic [2:0]             brk_hit_q;
  logic [31:0]            asi_rdata_q;
  bdp_pkg::bdp_status_t   stat_q;
  bdp_pkg::bdp_state_t    state_q;
  logic [15:0]            cnt_q;
  logic [3:0]             rst_cnt_q;
  logic                   test_seen_q;

  wire [31:0] wcmd      = hwdata;
  wire [7:0]  cmd_asi   = wcmd[`BDP_CMD_ASI_LSB +: 8];
  wire        is_bist   = (cmd_asi == `BDP_ASI_SELFTEST);
  wire        sw_store  = dp_wr & sel_cmd & is_bist
                          & wcmd[`BDP_CMD_STORE_BIT];
  wire        sw_load   = dp_wr & sel_cmd & is_bist
                          & wcmd[`BDP_CMD_LOAD_BIT];
  wire        va_short  = (va_q == `BDP_VA_SHORT);
  wire        va_long   = (va_q == `BDP_VA_LONG);
  wire        jreq      = ctrl_q[`BDP_CTRL_JREQ_BIT] | scan_bist_req;
  // Start only from idle; unknown addresses are ignored
  wire        start     = (state_q == bdp_pkg::BDP_IDLE)
                          & (((sw_store) & (va_short | va_long))
                             | jreq); // see [RULE1] see [RULE15]
  wire        start_long = sw_store & va_long; // see [RULE2]
  wire        run_done  = (state_q == bdp_pkg::BDP_RUN) & (cnt_q == 16'd0);
  wire        ext_abort = ~ext_reset_n;

  // ----------------------------------------
  // Self test sequencer
  // ----------------------------------------
  logic [31:0] sig;
  wire         misr_clear = start;
  wire         misr_step  = (state_q == bdp_pkg::BDP_RUN);
  wire [31:0]  pattern    = {cnt_q, ~cnt_q}; // see [RULE3]

  bdp_misr u_misr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clear   (misr_clear),
    .step    (misr_step),
    .data    (pattern),
    .sig     (sig)
  );

  // Golden signature for the short run; long has none
  parameter logic [31:0] SHORT_GOLDEN = 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= bdp_pkg::BDP_IDLE;
      cnt_q     <= 16'd0;
      rst_cnt_q <= 4'd0;
    end else if (ext_abort) begin
      state_q   <= bdp_pkg::BDP_IDLE; // see [RULE4]
      cnt_q     <= 16'd0;
      rst_cnt_q <= 4'd0;
    end else begin
      case (state_q)
        bdp_pkg::BDP_IDLE: begin
          if (start) begin
            state_q <= bdp_pkg::BDP_RUN;
            cnt_q   <= start_long ? `BDP_LONG_CYCLES : `BDP_SHORT_CYCLES;
          end
        end
        bdp_pkg::BDP_RUN: begin
          if (run_done) begin
            state_q   <= bdp_pkg::BDP_RESET; // see [RULE5]
            rst_cnt_q <= `BDP_RST_CYCLES;
          end else begin
            cnt_q <= cnt_q - 16'd1;
          end
        end
        bdp_pkg::BDP_RESET: begin
          if (rst_cnt_q == 4'd1) begin
            state_q <= bdp_pkg::BDP_BOOT;
          end
          rst_cnt_q <= rst_cnt_q - 4'd1;
        end
        bdp_pkg::BDP_BOOT: begin
          state_q <= bdp_pkg::BDP_IDLE; // see [RULE17]
        end
        default: begin
          state_q <= bdp_pkg::BDP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status and result capture
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= '0;
    end else if (ext_abort && state_q == bdp_pkg::BDP_RUN) begin
      stat_q.aborted <= 1'b1; // see [RULE18]
      stat_q.pass    <= 1'b0;
      stat_q.done    <= 1'b0;
    end else if (start) begin
      stat_q          <= '0;
      stat_q.long_run <= start_long;
    end else if (run_done) begin
      stat_q.done <= 1'b1;
      // Long run never reports pass
      stat_q.pass <= ~stat_q.long_run
                     & (sig == SHORT_GOLDEN); // see [RULE9]
    end
  end

  // Alternate-space load result
  wire [31:0] stat_word = {28'h000_0000, stat_q.long_run, stat_q.aborted,
                           stat_q.done, stat_q.pass};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      asi_rdata_q <= 32'h0000_0000;
    end else if (sw_load) begin
      asi_rdata_q <= va_long  ? stat_word :
                     va_short ? sig : 32'h0000_0000; // see [RULE6]
    end
  end

  // ----------------------------------------
  // Control register and internal reset
  // ----------------------------------------
  wire int_rst = (state_q == bdp_pkg::BDP_RESET);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= `BDP_CTRL_RESET;
      va_q     <= 32'h0000_0000;
      brk_en_q <= 3'b000;
    end else if (int_rst) begin
      ctrl_q[`BDP_CTRL_PAR_BIT]  <= 1'b0; // see [RULE7]
      ctrl_q[`BDP_CTRL_JREQ_BIT] <= 1'b0;
      brk_en_q <= 3'b000;
    end else if (dp_wr) begin
      if (sel_ctrl) begin
        ctrl_q <= hwdata;
      end else if (sel_addr) begin
        va_q <= hwdata;
      end else if (sel_brk) begin
        brk_en_q <= hwdata[2:0];
      end
    end else if (start) begin
      ctrl_q[`BDP_CTRL_JREQ_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Breakpoint strobe
  // ----------------------------------------
  wire [2:0] bp_src = {cycle_bp_hit, data_bp_hit, code_bp_hit};
  wire       bp_any = |(bp_src & brk_en_q); // see [RULE11]
  logic [3:0] stb_cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stb_cnt_q <= 4'd0;
      brk_hit_q <= 3'b000;
    end else begin
      if (bp_any) begin
        stb_cnt_q <= `BDP_STROBE_CYCLES; // see [RULE10]
      end else if (stb_cnt_q != 4'd0) begin
        stb_cnt_q <= stb_cnt_q - 4'd1;
      end
      // Sticky hit record; a new hit wins over clear
      brk_hit_q <= (bp_src & brk_en_q)
                   | (brk_hit_q & ~((dp_wr & sel_brk)
                      ? hwdata[`BDP_BRK_HIT_LSB +: 3] : 3'b000));
    end
  end

  // ----------------------------------------
  // Pin outputs, all registered
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      breakpoint_strobe_out <= 1'b0;
      pipeline_monitor_bus  <= 10'h000;
      pipe_oe_n             <= 1'b1;
      internal_reset        <= 1'b0;
      boot_fetch            <= 1'b0;
      boot_addr             <= `BDP_BOOT_VECTOR;
      parity_enable         <= 1'b1;
      test_seen_q           <= 1'b0;
    end else begin
      breakpoint_strobe_out <= bp_any | (stb_cnt_q > 4'd1);
      pipeline_monitor_bus  <= pipe_state; // see [RULE12]
      pipe_oe_n             <= test_pin | ctrl_q[`BDP_CTRL_TEST_BIT]; // see [RULE13]
      internal_reset        <= int_rst; // see [RULE8]
      boot_fetch            <= (state_q == bdp_pkg::BDP_BOOT);
      boot_addr             <= `BDP_BOOT_VECTOR; // see [RULE17]
      parity_enable         <= ctrl_q[`BDP_CTRL_PAR_BIT];
      test_seen_q           <= test_seen_q | test_pin; // see [RULE14]
    end
  end

  // ----------------------------------------
  // Bus read data and response
  // ----------------------------------------
  wire [31:0] rd_mux =
    sel_ctrl ? ctrl_q :
    sel_addr ? va_q :
    sel_rdat ? asi_rdata_q :
    sel_stat ? {25'h000_0000, test_seen_q, 2'b00, stat_word[3:0]}
             | {24'h00_0000, 5'h00, state_q} :
    sel_brk  ? {25'h000_0000, brk_hit_q, 1'b0, brk_en_q} :
    sel_pipe ? {22'h00_0000, pipeline_monitor_bus} :
    32'h0000_0000;

  always_comb begin
    hrdata    = dp_rd ? rd_mux : 32'h0000_0000;
    hreadyout = 1'b1;
    hresp     = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
    end else if (hready) begin
      ap_q <= ap_d;
    end
  end

endmodule // bdp_top

// *** bdp_core_model.sv ***
module bdp_core_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [2:0] fire,
  output logic            code_bp_hit,
  output logic            data_bp_hit,
  output logic            cycle_bp_hit,
  output logic [9:0]      pipe_state
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Core side: breakpoint sources and state
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cycle_bp_hit, data_bp_hit, code_bp_hit} <= 3'h0;
      pipe_state <= 10'h000;
    end else begin
      {cycle_bp_hit, data_bp_hit, code_bp_hit} <= fire;
      pipe_state <= pipe_state + 10'h001;
    end
  end
endmodule // bdp_core_model

// *** bdp_properties.sv ***
`include "bdp_defs.svh"

module bdp_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ext_reset_n,
  input wire logic        test_pin,
  input wire logic        code_bp_hit,
  input wire logic        data_bp_hit,
  input wire logic        cycle_bp_hit,
  input wire logic [9:0]  pipe_state,
  input wire logic        breakpoint_strobe_out,
  input wire logic [9:0]  pipeline_monitor_bus,
  input wire logic        pipe_oe_n,
  input wire logic        internal_reset,
  input wire logic        boot_fetch,
  input wire logic [31:0] boot_addr,
  input wire logic        parity_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  wire hit_any = code_bp_hit | data_bp_hit | cycle_bp_hit;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  rst_pulse_a: assert property ($rose(internal_reset) |->
    internal_reset [*8] ##1 !internal_reset) else $error("reset pulse");
  boot_after_a: assert property ($fell(internal_reset) |->
    ##[0:2] boot_fetch) else $error("no boot fetch");
  boot_vec_a: assert property (boot_fetch |->
    boot_addr == `BDP_BOOT_VECTOR ##1 !boot_fetch) else $error("boot");
  par_clr_a: assert property (internal_reset |=>
    !parity_enable) else $error("parity not cleared");
  strobe_len_a: assert property ($rose(breakpoint_strobe_out) |->
    breakpoint_strobe_out [*2] ##1 !breakpoint_strobe_out)
    else $error("strobe length");
  strobe_src_a: assert property ($rose(breakpoint_strobe_out) |->
    $past(hit_any, 1) || $past(hit_any, 2)) else $error("strobe cause");
  pipe_mon_a: assert property ($past(hresetn) |->
    pipeline_monitor_bus == $past(pipe_state)) else $error("monitor");
  float_out_a: assert property (test_pin |=> pipe_oe_n)
    else $error("monitor not floated");
  abort_run_a: assert property (!ext_reset_n && !internal_reset |=>
    !internal_reset) else $error("reset after abort");
  cover property ($rose(internal_reset));
  cover property (boot_fetch);
  cover property ($rose(breakpoint_strobe_out));
endmodule // bdp_properties

bind bdp_top bdp_properties u_props (
  .hclk(hclk), .hresetn(hresetn), .ext_reset_n(ext_reset_n),
  .test_pin(test_pin), .code_bp_hit(code_bp_hit),
  .data_bp_hit(data_bp_hit), .cycle_bp_hit(cycle_bp_hit),
  .pipe_state(pipe_state), .breakpoint_strobe_out(breakpoint_strobe_out),
  .pipeline_monitor_bus(pipeline_monitor_bus), .pipe_oe_n(pipe_oe_n),
  .internal_reset(internal_reset), .boot_fetch(boot_fetch),
  .boot_addr(boot_addr), .parity_enable(parity_enable)
);

// *** tb_top.sv ***
`include "bdp_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_reset_n = 1;
  logic        test_pin = 0, scan_bist_req = 0, seen;
  logic [31:0] haddr = '0, hwdata = '0, rd, hrdata, boot_addr;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2, fire = '0;
  logic        hreadyout, hresp, code_hit, data_hit, cyc_hit, strobe;
  logic        pipe_oe_n, internal_reset, boot_fetch, parity_enable;
  logic [9:0]  pipe_state, mon_bus;
  int          mismatches = 0, checks = 0, cyc = 0;
  localparam logic [31:0] CMD_ST = {16'h0, `BDP_ASI_SELFTEST, 8'h01};
  localparam logic [31:0] CMD_LD = {16'h0, `BDP_ASI_SELFTEST, 8'h02};

  always #5 hclk = ~hclk;

  bdp_core_model core (.hclk(hclk), .hresetn(hresetn), .fire(fire),
    .code_bp_hit(code_hit), .data_bp_hit(data_hit),
    .cycle_bp_hit(cyc_hit), .pipe_state(pipe_state));

  bdp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_reset_n(ext_reset_n), .test_pin(test_pin),
    .scan_bist_req(scan_bist_req), .code_bp_hit(code_hit),
    .data_bp_hit(data_hit), .cycle_bp_hit(cyc_hit),
    .pipe_state(pipe_state), .breakpoint_strobe_out(strobe),
    .pipeline_monitor_bus(mon_bus), .pipe_oe_n(pipe_oe_n),
    .internal_reset(internal_reset), .boot_fetch(boot_fetch),
    .boot_addr(boot_addr), .parity_enable(parity_enable));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wait_rst(input int lim, output logic s);
    s = 1'b0;
    for (int i = 0; i < lim && !s; i++) begin
      @(posedge hclk);
      if (internal_reset === 1'b1) s = 1'b1;
    end
  endtask

  task automatic asi_load(input logic [31:0] va);
    bus(1'b1, `BDP_OFF_ASI_ADDR, va, rd);
    bus(1'b1, `BDP_OFF_ASI_CMD, CMD_LD, rd);
    bus(1'b0, `BDP_OFF_ASI_RDATA, 32'h0, rd);
  endtask

  task automatic start(input logic [31:0] va);
    bus(1'b1, `BDP_OFF_ASI_ADDR, va, rd);
    bus(1'b1, `BDP_OFF_ASI_CMD, CMD_ST, rd);
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `BDP_OFF_CTRL, 32'h0, rd);
    chk(rd, `BDP_CTRL_RESET);
    bus(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, `BDP_OFF_BRK, 32'h7, rd);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        bus(1'b0, `BDP_OFF_BRK, 32'h0, rd);
        chk(rd, 32'h77);
        bus(1'b1, `BDP_OFF_BRK, 32'h70, rd);
      end
      fire <= (i == 3) ? 3'h1 : 3'h1 << i;
      @(posedge hclk);
      fire <= 3'h0;
      seen = 1'b0;
      repeat (4) begin
        @(posedge hclk);
        if (strobe === 1'b1) seen = 1'b1;
      end
      chk({31'h0, seen}, {31'h0, i != 3});
      repeat (4) @(posedge hclk);
    end
    start(`BDP_VA_SHORT);
    wait_rst(200, seen);
    chk({31'h0, seen}, 32'h0);
    wait_rst(200, seen);
    chk({31'h0, seen}, 32'h1);
    repeat (8) @(posedge hclk);
    chk({31'h0, boot_fetch}, 32'h1);
    chk(boot_addr, `BDP_BOOT_VECTOR);
    repeat (4) @(posedge hclk);
    chk({31'h0, parity_enable}, 32'h0);
    asi_load(`BDP_VA_LONG);
    chk({31'h0, rd[1]}, 32'h1);
    bus(1'b1, `BDP_OFF_CTRL, 32'h1, rd);
    start(`BDP_VA_LONG);
    wait_rst(300, seen);
    chk({31'h0, seen}, 32'h0);
    ext_reset_n <= 1'b0;
    repeat (4) @(posedge hclk);
    ext_reset_n <= 1'b1;
    wait_rst(1200, seen);
    chk({31'h0, seen}, 32'h0);
    asi_load(`BDP_VA_LONG);
    chk({30'h0, rd[2], rd[0]}, 32'h2);
    start(32'h40);
    wait_rst(400, seen);
    chk({31'h0, seen}, 32'h0);
    scan_bist_req <= 1'b1;
    @(posedge hclk);
    scan_bist_req <= 1'b0;
    wait_rst(1300, seen);
    chk({31'h0, seen}, 32'h1);
    repeat (20) @(posedge hclk);
    test_pin <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({31'h0, pipe_oe_n}, 32'h1);
    test_pin <= 1'b0;
    bus(1'b0, `BDP_OFF_STATUS, 32'h0, rd);
    chk({31'h0, rd[6]}, 32'h1);
    bus(1'b1, `BDP_OFF_CTRL, 32'h2, rd);
    repeat (2) @(posedge hclk);
    chk({31'h0, pipe_oe_n}, 32'h1);
    repeat (3) @(posedge hclk);
    #1;
    chk({22'h0, mon_bus}, {22'h0, pipe_state - 10'h001});
    stop_test();
  end
endmodule // tb_top
